// *** hw/iav_entry_timer.sv ***
`default_nettype none
module iav_entry_timer
	import iav_pkg::*;
#(
	parameter logic [iav_pkg::CYC_W-1:0] MAX_CYCLES = iav_pkg::ENTRY_MAX_CYCLES
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic start_in,
	input wire logic insn_cycle_in,
	input wire logic fetch_valid_in,
	input wire logic [iav_pkg::ADDR_W-1:0] fetch_addr_in,
	input wire logic [iav_pkg::ADDR_W-1:0] target_in,
	output logic [iav_pkg::CYC_W-1:0] cycles_out,
	output logic late_out,
	output logic reached_out
);
	// ----------------------------------------
	// branch-to-table-entry latency
	// ----------------------------------------
	iav_entry_e state;
	iav_entry_e next_state;
	logic [CYC_W-1:0] count;
	wire hit_w = fetch_valid_in && (fetch_addr_in == target_in);
	wire sat_w = &count;
	wire over_w = count > MAX_CYCLES;

	// a new branch always restarts the measurement
	always_comb begin
		next_state = state;
		unique case (state)
			ENT_IDLE: if (start_in) next_state = ENT_COUNT;
			ENT_COUNT: if (hit_w) next_state = ENT_DONE;
			ENT_DONE: if (start_in) next_state = ENT_COUNT;
		endcase
	end

	// counter saturates so a runaway entry cannot wrap back to in-time
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state <= ENT_IDLE;
			count <= '0;
			late_out <= 1'b0;
			reached_out <= 1'b0;
		end else begin
			state <= start_in ? ENT_COUNT : next_state;
			reached_out <= (state == ENT_COUNT) && hit_w && !start_in;
			if (start_in) begin
				count <= '0;
				late_out <= 1'b0;
			end else if (state == ENT_COUNT) begin
				if (insn_cycle_in && !sat_w) count <= count + 1'b1;
				if (over_w) late_out <= 1'b1;
			end
		end
	end
	assign cycles_out = count;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	entry_late_a: assert property ((state == ENT_COUNT) && over_w && !start_in |=> late_out)
		else $error("entry beyond allowed cycles not flagged");
endmodule
`default_nettype wire

// *** hw/iav_pkg.sv ***
`default_nettype none
package iav_pkg;
	// ----------------------------------------
	// sizes
	// ----------------------------------------
	localparam int NUM_SRC = 14;
	localparam int IDX_W = 4;
	localparam int BYTE_W = 8;
	localparam int ADDR_W = 16;
	localparam int CYC_W = 4;

	// ----------------------------------------
	// serial status and flag register bits
	// ----------------------------------------
	localparam int SER_DONE_BIT = 0;
	localparam int SER_STOP_BIT = 6;
	localparam int FLAG_SER_BIT = 5;
	localparam int FLAG_SHARED_BIT = 6;

	// ----------------------------------------
	// vector codes and fetch addresses
	// ----------------------------------------
	localparam logic [7:0] VEC_BASE = 8'h80;
	localparam logic [7:0] VEC_LAST = 8'hb4;
	localparam int VEC_SHIFT = 2;
	localparam logic [15:0] ADDR_VECTOR = 16'h0053;
	localparam logic [15:0] ADDR_HIGH = 16'h0054;
	localparam logic [15:0] ADDR_LOW = 16'h0055;
	localparam logic [7:0] LONG_JUMP_OPCODE = 8'h02;
	localparam logic [3:0] ENTRY_MAX_CYCLES = 4'h8;

	// ----------------------------------------
	// entry timer states, gray along the path
	// ----------------------------------------
	typedef enum logic [1:0] {
		ENT_IDLE = 2'b00,
		ENT_COUNT = 2'b01,
		ENT_DONE = 2'b11
	} iav_entry_e;
endpackage
`default_nettype wire

// *** hw/iav_prio_enc.sv ***
`default_nettype none
module iav_prio_enc #(
	parameter int N = 14,
	parameter int IW = 4
) (
	input wire logic [N-1:0] req_in,
	output logic any_out,
	output logic [IW-1:0] idx_out
);
	// ----------------------------------------
	// lowest index wins
	// ----------------------------------------
	logic [N:0] seen;
	logic [IW-1:0] idx_chain [N+1];

	assign seen[0] = 1'b0;
	assign idx_chain[0] = '0;
	// each stage only contributes if nothing below it was pending
	for (genvar i = 0; i < N; i++) begin : g_stage
		wire hit = req_in[i] & ~seen[i];
		assign seen[i+1] = seen[i] | req_in[i];
		assign idx_chain[i+1] = idx_chain[i] | (hit ? IW'(i) : '0);
	end
	assign any_out = seen[N];
	assign idx_out = idx_chain[N];
endmodule
`default_nettype wire

// *** hw/iav_top.sv ***
`default_nettype none
module iav_top
	import iav_pkg::*;
(
	input wire logic CLK_IN,
	input wire logic RSTN_IN,
	input wire logic [iav_pkg::BYTE_W-1:0] SERIAL_CTRL_STATUS_REG_IN,
	input wire logic SERIAL_REG_ACCESS_IN,
	input wire logic SERIAL_DONE_ENABLE_IN,
	input wire logic STOP_SOURCE_ENABLE_IN,
	input wire logic EXT_INT_FLAG_WR_IN,
	input wire logic [iav_pkg::BYTE_W-1:0] EXT_INT_FLAG_WDATA_IN,
	output logic [iav_pkg::BYTE_W-1:0] EXT_INT_FLAG_REG_OUT,
	output logic SERIAL_IRQ_OUT,
	input wire logic [iav_pkg::NUM_SRC-1:0] SRC_EVENT_IN,
	input wire logic [iav_pkg::NUM_SRC-1:0] SOURCE_ENABLE_BIT_IN,
	input wire logic SRC_REQ_WR_IN,
	input wire logic [iav_pkg::NUM_SRC-1:0] SRC_REQ_WDATA_IN,
	output logic [iav_pkg::NUM_SRC-1:0] SRC_REQUEST_OUT,
	input wire logic SHARED_INT_ENABLE_IN,
	input wire logic SHARED_AUTOVECTOR_ENABLE_IN,
	output logic SHARED_MAIN_INTERRUPT_OUT,
	output logic [iav_pkg::BYTE_W-1:0] SHARED_VECTOR_BYTE_OUT,
	output logic [iav_pkg::ADDR_W-1:0] SHARED_BRANCH_ADDR_OUT,
	input wire logic FETCH_VALID_IN,
	input wire logic [iav_pkg::ADDR_W-1:0] FETCH_ADDR_IN,
	input wire logic [iav_pkg::BYTE_W-1:0] FETCH_DATA_IN,
	output logic FETCH_VALID_OUT,
	output logic [iav_pkg::BYTE_W-1:0] FETCH_DATA_OUT,
	output logic VECTOR_OPCODE_OK_OUT,
	input wire logic BRANCH_ACK_IN,
	input wire logic INSN_CYCLE_IN,
	output logic [iav_pkg::CYC_W-1:0] ENTRY_CYCLES_OUT,
	output logic ENTRY_LATE_OUT,
	output logic ENTRY_REACHED_OUT
);
	import iav_pkg::*;

	// ----------------------------------------
	// serial bus interrupt
	// ----------------------------------------
	logic done_q;
	logic stop_q;
	logic ser_flag;
	logic next_ser_flag;

	// edge detect on the controller's status bits, same clock domain
	wire done_w = SERIAL_CTRL_STATUS_REG_IN[SER_DONE_BIT];
	wire stop_w = SERIAL_CTRL_STATUS_REG_IN[SER_STOP_BIT];
	wire done_rise_w = done_w & ~done_q;
	wire stop_fall_w = ~stop_w & stop_q;
	wire ser_set_w = (done_rise_w & SERIAL_DONE_ENABLE_IN) | (stop_fall_w & STOP_SOURCE_ENABLE_IN);
	wire ser_wr_clr_w = EXT_INT_FLAG_WR_IN & ~EXT_INT_FLAG_WDATA_IN[FLAG_SER_BIT];
	wire ser_clr_w = ser_wr_clr_w | SERIAL_REG_ACCESS_IN;
	// a new event in the clearing cycle survives the clear
	assign next_ser_flag = ser_set_w | (ser_flag & ~ser_clr_w);

	// reset values assume controller idle: done low, stop low
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			done_q <= 1'b0;
			stop_q <= 1'b0;
			ser_flag <= 1'b0;
		end else begin
			done_q <= done_w;
			stop_q <= stop_w;
			ser_flag <= next_ser_flag;
		end
	end

	// ----------------------------------------
	// shared source requests
	// ----------------------------------------
	logic [NUM_SRC-1:0] req;
	logic [NUM_SRC-1:0] next_req;
	logic main_flag;
	logic next_main_flag;

	// write-one-to-clear; a same-cycle event keeps the bit set
	wire [NUM_SRC-1:0] req_clr_w = SRC_REQ_WR_IN ? SRC_REQ_WDATA_IN : '0;
	assign next_req = SRC_EVENT_IN | (req & ~req_clr_w);
	wire [NUM_SRC-1:0] pend_w = req & SOURCE_ENABLE_BIT_IN;
	wire [NUM_SRC-1:0] left_w = req & ~req_clr_w & SOURCE_ENABLE_BIT_IN;
	wire new_ev_w = |(SRC_EVENT_IN & SOURCE_ENABLE_BIT_IN);
	// clearing one source lets the rest fire again; if main is still set the edge is absorbed
	wire rereq_w = SRC_REQ_WR_IN & (|req_clr_w) & (|left_w);
	wire main_clr_w = EXT_INT_FLAG_WR_IN & ~EXT_INT_FLAG_WDATA_IN[FLAG_SHARED_BIT];
	wire main_set_w = new_ev_w | rereq_w;
	assign next_main_flag = main_set_w | (main_flag & ~main_clr_w);

	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			req <= '0;
			main_flag <= 1'b0;
		end else begin
			req <= next_req;
			main_flag <= next_main_flag;
		end
	end

	// ----------------------------------------
	// vector construction
	// ----------------------------------------
	logic any_pend;
	logic [IDX_W-1:0] top_idx;
	logic [BYTE_W-1:0] vector;

	iav_prio_enc #(
		.N(NUM_SRC),
		.IW(IDX_W)
	) u_prio (
		.req_in(pend_w),
		.any_out(any_pend),
		.idx_out(top_idx)
	);

	// code = base plus four per priority step
	wire [BYTE_W-1:0] code_w = BYTE_W'(VEC_BASE + (BYTE_W'(top_idx) << VEC_SHIFT));

	// vector holds its last code when nothing is pending
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			vector <= VEC_BASE;
		end else if (any_pend) begin
			vector <= code_w;
		end
	end

	// ----------------------------------------
	// instruction fetch substitution
	// ----------------------------------------
	logic fetch_valid;
	logic [BYTE_W-1:0] fetch_data;
	logic opcode_ok;
	logic [BYTE_W-1:0] page;

	wire at_op_w = FETCH_VALID_IN && (FETCH_ADDR_IN == ADDR_VECTOR);
	wire at_high_w = FETCH_VALID_IN && (FETCH_ADDR_IN == ADDR_HIGH);
	wire subst_w = FETCH_VALID_IN && SHARED_AUTOVECTOR_ENABLE_IN && (FETCH_ADDR_IN == ADDR_LOW);
	wire [BYTE_W-1:0] fetch_mux_w = subst_w ? vector : FETCH_DATA_IN;

	// one cycle of latency on the fetch path keeps the data output registered
	always_ff @(posedge CLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			fetch_valid <= 1'b0;
			fetch_data <= '0;
			opcode_ok <= 1'b0;
			page <= '0;
		end else begin
			fetch_valid <= FETCH_VALID_IN;
			if (FETCH_VALID_IN) fetch_data <= fetch_mux_w;
			if (at_op_w) opcode_ok <= (FETCH_DATA_IN == LONG_JUMP_OPCODE);
			if (at_high_w) page <= FETCH_DATA_IN;
		end
	end

	// ----------------------------------------
	// entry latency
	// ----------------------------------------
	// table entry is the page byte joined to the current vector
	wire [ADDR_W-1:0] target_w = {page, vector};

	iav_entry_timer u_timer (
		.clk_in(CLK_IN),
		.rstn_in(RSTN_IN),
		.start_in(BRANCH_ACK_IN),
		.insn_cycle_in(INSN_CYCLE_IN),
		.fetch_valid_in(FETCH_VALID_IN),
		.fetch_addr_in(FETCH_ADDR_IN),
		.target_in(target_w),
		.cycles_out(ENTRY_CYCLES_OUT),
		.late_out(ENTRY_LATE_OUT),
		.reached_out(ENTRY_REACHED_OUT)
	);

	// ----------------------------------------
	// outputs
	// ----------------------------------------
	// core pushes its own counter; this block only names the target
	assign SHARED_BRANCH_ADDR_OUT = ADDR_VECTOR;
	assign SHARED_MAIN_INTERRUPT_OUT = main_flag & SHARED_INT_ENABLE_IN;
	assign SERIAL_IRQ_OUT = ser_flag;
	assign SRC_REQUEST_OUT = req;
	assign SHARED_VECTOR_BYTE_OUT = vector;
	assign FETCH_VALID_OUT = fetch_valid;
	assign FETCH_DATA_OUT = fetch_data;
	assign VECTOR_OPCODE_OK_OUT = opcode_ok;
	// only the two flags live here; other bits belong elsewhere and read zero
	always_comb begin
		EXT_INT_FLAG_REG_OUT = '0;
		EXT_INT_FLAG_REG_OUT[FLAG_SER_BIT] = ser_flag;
		EXT_INT_FLAG_REG_OUT[FLAG_SHARED_BIT] = main_flag;
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (!RSTN_IN);

	ser_done_irq_a: assert property (done_rise_w && SERIAL_DONE_ENABLE_IN |=> SERIAL_IRQ_OUT)
		else $error("done rise did not raise serial interrupt");
	ser_stop_irq_a: assert property (stop_fall_w && STOP_SOURCE_ENABLE_IN |=> SERIAL_IRQ_OUT)
		else $error("stop fall did not raise serial interrupt");
	ser_gate_a: assert property ($rose(ser_flag) |-> $past(ser_set_w))
		else $error("serial interrupt raised without an enabled source");
	ser_wr_clr_a: assert property (ser_wr_clr_w && !ser_set_w |=> !SERIAL_IRQ_OUT)
		else $error("flag write of zero left serial request");
	ser_access_a: assert property (SERIAL_REG_ACCESS_IN && !ser_set_w |=> !SERIAL_IRQ_OUT)
		else $error("register access left serial request");
	main_event_a: assert property (new_ev_w |=> EXT_INT_FLAG_REG_OUT[FLAG_SHARED_BIT])
		else $error("enabled source event missed main request");
	vec_first_a: assert property (pend_w[0] |=> SHARED_VECTOR_BYTE_OUT == VEC_BASE)
		else $error("highest priority source not chosen");
	vec_last_a: assert property (pend_w == {1'b1, {(NUM_SRC-1){1'b0}}} |=> SHARED_VECTOR_BYTE_OUT == VEC_LAST)
		else $error("lowest source vector code wrong");
	subst_a: assert property (subst_w |=> FETCH_VALID_OUT && FETCH_DATA_OUT == $past(vector))
		else $error("vector not substituted at low byte");
	no_subst_a: assert property (FETCH_VALID_IN && !subst_w |=> FETCH_DATA_OUT == $past(FETCH_DATA_IN))
		else $error("fetch data altered outside low byte");
	rereq_a: assert property (rereq_w |=> main_flag)
		else $error("pending source failed to re-request main");
	main_clr_a: assert property (main_clr_w && !main_set_w |=> !main_flag ##1 (main_flag || !$past(main_set_w)))
		else $error("main request not cleared by zero write");
	req_set_a: assert property ((SRC_REQUEST_OUT & $past(SRC_EVENT_IN)) == $past(SRC_EVENT_IN))
		else $error("source event did not set its request");
	vec_enabled_a: assert property (any_pend |-> pend_w[top_idx] && SOURCE_ENABLE_BIT_IN[top_idx])
		else $error("vector chose a disabled or idle source");
endmodule
`default_nettype wire

// *** verification/iav_core_model.sv ***
`default_nettype none
// ----------------------------------------
// core and firmware stand-in for shared entry
// ----------------------------------------
module iav_core_model
	import iav_pkg::*;
(
	input wire logic clk_in,
	input wire logic start_in,
	input wire logic [7:0] page_in,
	input wire logic [7:0] fetched_in,
	output logic busy_out,
	output logic [7:0] vec_out,
	output logic ack_out,
	output logic insn_out,
	output logic fv_out,
	output logic [15:0] fa_out,
	output logic [7:0] fd_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// one instruction cycle a fetch; released lines show the inverse so stale bytes never match
	task automatic fetch(input logic [15:0] a, input logic [7:0] d);
		@(negedge clk_in);
		fv_out = 1'b1;
		fa_out = a;
		fd_out = d;
		insn_out = 1'b1;
		@(negedge clk_in);
		fv_out = 1'b0;
		fa_out = ~a;
		fd_out = ~d;
		insn_out = 1'b0;
	endtask
	// take the branch, walk the jump at the vector location, then the table entry
	initial begin
		busy_out = 1'b0;
		vec_out = 8'h00;
		ack_out = 1'b0;
		insn_out = 1'b0;
		fv_out = 1'b0;
		fa_out = 16'hffff;
		fd_out = 8'hff;
		forever begin
			@(posedge clk_in iff start_in);
			busy_out = 1'b1;
			@(negedge clk_in);
			ack_out = 1'b1;
			@(negedge clk_in);
			ack_out = 1'b0;
			fetch(ADDR_VECTOR, LONG_JUMP_OPCODE);
			fetch(ADDR_HIGH, page_in);
			fetch(ADDR_LOW, VEC_BASE);
			vec_out = fetched_in;
			fetch({page_in, vec_out}, LONG_JUMP_OPCODE);
			busy_out = 1'b0;
		end
	end
endmodule
`default_nettype wire

// *** verification/iav_top_tb.sv ***
`default_nettype none
module iav_top_tb;
	import iav_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rstn, acc, den, sen, fwr, rwr, sie, av, go, seen, busy, opc, late, reached, irq, main, fvo, ack, insn, fv;
	logic [7:0] st, fwd, flag, vec, fdo, mvec, fd;
	logic [13:0] sev, en, rwd, req;
	logic [15:0] baddr, fa;
	logic [3:0] ecyc;
	int num_errors = 0;
	int total_checks = 0;
	int cycles = 0;
	int n;
	iav_top u_dut (.CLK_IN(clk), .RSTN_IN(rstn), .SERIAL_CTRL_STATUS_REG_IN(st), .SERIAL_REG_ACCESS_IN(acc),
		.SERIAL_DONE_ENABLE_IN(den), .STOP_SOURCE_ENABLE_IN(sen), .EXT_INT_FLAG_WR_IN(fwr),
		.EXT_INT_FLAG_WDATA_IN(fwd), .EXT_INT_FLAG_REG_OUT(flag), .SERIAL_IRQ_OUT(irq), .SRC_EVENT_IN(sev),
		.SOURCE_ENABLE_BIT_IN(en), .SRC_REQ_WR_IN(rwr), .SRC_REQ_WDATA_IN(rwd), .SRC_REQUEST_OUT(req),
		.SHARED_INT_ENABLE_IN(sie), .SHARED_AUTOVECTOR_ENABLE_IN(av), .SHARED_MAIN_INTERRUPT_OUT(main),
		.SHARED_VECTOR_BYTE_OUT(vec), .SHARED_BRANCH_ADDR_OUT(baddr), .FETCH_VALID_IN(fv), .FETCH_ADDR_IN(fa),
		.FETCH_DATA_IN(fd), .FETCH_VALID_OUT(fvo), .FETCH_DATA_OUT(fdo), .VECTOR_OPCODE_OK_OUT(opc),
		.BRANCH_ACK_IN(ack), .INSN_CYCLE_IN(insn), .ENTRY_CYCLES_OUT(ecyc), .ENTRY_LATE_OUT(late),
		.ENTRY_REACHED_OUT(reached));
	iav_core_model u_core (.clk_in(clk), .start_in(go), .page_in(8'h04), .fetched_in(fdo), .busy_out(busy),
		.vec_out(mvec), .ack_out(ack), .insn_out(insn), .fv_out(fv), .fa_out(fa), .fd_out(fd));
	// ----------------------------------------
	// clock, hang guard and reached monitor
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	// the reached pulse lasts one cycle, so keep it sticky; sampled away from the edge that launches it
	always @(negedge clk) begin
		cycles++;
		if (reached === 1'b1)
			seen = 1'b1;
		if (cycles > 5000) begin
			num_errors++;
			report_and_stop();
		end
	end
	// ----------------------------------------
	// shared helpers
	// ----------------------------------------
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge clk);
	endtask
	task automatic flag_wr(input logic [7:0] d);
		fwr = 1'b1;
		fwd = d;
		cyc(1);
		fwr = 1'b0;
	endtask
	task automatic req_clr(input logic [13:0] d);
		rwr = 1'b1;
		rwd = d;
		cyc(1);
		rwr = 1'b0;
	endtask
	task automatic ev(input logic [13:0] d);
		sev = d;
		cyc(1);
		sev = 14'h0000;
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic t_serial();
		st = 8'h01;
		cyc(3);
		chk("serial_irq", 1'b0, irq);
		st = 8'h00;
		den = 1'b1;
		cyc(1);
		st = 8'h01;
		cyc(2);
		chk("serial_irq", 1'b1, irq);
		chk("flag_serial", 1'b1, flag[FLAG_SER_BIT]);
		acc = 1'b1;
		cyc(1);
		acc = 1'b0;
		cyc(2);
		chk("serial_irq", 1'b0, irq);
		st = 8'h41;
		sen = 1'b1;
		cyc(2);
		st = 8'h01;
		cyc(2);
		chk("serial_irq", 1'b1, irq);
		flag_wr(8'hdf);
		cyc(1);
		chk("serial_irq", 1'b0, irq);
	endtask
	// every source alone gives its own code, then main first and request second
	task automatic t_vectors();
		for (int i = 0; i < NUM_SRC; i++) begin
			ev(14'h0001 << i);
			cyc(1);
			chk("request", 14'h0001 << i, req);
			chk("main", 1'b1, main);
			chk("vector", VEC_BASE + 8'(4 * i), vec);
			flag_wr(8'hbf);
			req_clr(14'h0001 << i);
			cyc(1);
			chk("main", 1'b0, main);
			chk("request", 14'h0000, req);
		end
	endtask
	// disabled source 0 pending too; clearing one request re-raises main
	task automatic t_priority();
		en = 14'h3ffe;
		ev(14'h2009);
		cyc(1);
		chk("vector", 8'h8c, vec);
		flag_wr(8'hbf);
		req_clr(14'h0008);
		cyc(1);
		chk("main", 1'b1, main);
		chk("vector", 8'hb4, vec);
		flag_wr(8'hbf);
		req_clr(14'h3fff);
		cyc(1);
		chk("main", 1'b0, main);
	endtask
	task automatic t_entry(input logic av_on, input logic [7:0] exp_low);
		av = av_on;
		ev(14'h0200);
		cyc(1);
		seen = 1'b0;
		go = 1'b1;
		cyc(1);
		go = 1'b0;
		n = 0;
		while (busy === 1'b1 && n < 60) begin
			cyc(1);
			n++;
		end
		// let the reached pulse land in the sticky monitor before judging it
		cyc(2);
		chk("low_byte", exp_low, mvec);
		chk("entry_cycles", 16'h0004, ecyc);
		sie = 1'b0;
		cyc(1);
		chk("main_gated", 1'b0, main);
		sie = 1'b1;
		cyc(1);
		chk("main_ungated", 1'b1, main);
		chk("opcode_ok", 1'b1, opc);
		chk("branch_addr", ADDR_VECTOR, baddr);
		chk("reached", av_on, seen);
		chk("late", 1'b0, late);
		flag_wr(8'hbf);
		req_clr(14'h3fff);
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{rstn, acc, den, sen, fwr, rwr, av, go, seen} = '0;
		sie = 1'b1;
		st = 8'h00;
		fwd = 8'hff;
		sev = 14'h0000;
		en = 14'h3fff;
		rwd = 14'h0000;
		cyc(4);
		rstn = 1'b1;
		cyc(1);
		chk("vector_reset", VEC_BASE, vec);
		t_serial();
		t_vectors();
		t_priority();
		t_entry(1'b1, 8'ha4);
		t_entry(1'b0, VEC_BASE);
		report_and_stop();
	end
endmodule
`default_nettype wire
